// >>> hw/link_sense_convert_exec.sv
// executor for link-and-jump, sense indicator and conversion instructions
// assumes memory answers a read in the cycle after o_mem_rd, and the
// sequencer holds i_instr stable while o_busy is high
//
// Summary of operation
// - link-and-jump stores chosen counter plus one, then jumps to address plus one
// - link-and-jump writes zeros in word bits 16-25
// - select code 0001 saves control counter plus one
// - codes 0011 to 1111 save that channel address counter plus one
// - code 0010 saves memory address register plus one
// - link-and-jump allows indirection, no field selection
// - set-indicator sets the chosen sense indicator, ignoring address fields
// - codes 1000 to 1111 pick indicators one to eight
// - reset-indicator clears the chosen indicator in two cycles
// - indicator jump loads address if set, else increments counter
// - testing leaves indicator unchanged; jump target may be indirect
// - set and reset skip indirection, field selection, multiword handling
// - load-to-decimal reads three words, strips zones, packs two registers; the code writes six digits and the sign as one o_ar_wdata word
// - load-to-decimal assumes numeric characters, no zone check
// - load-to-decimal signs come from least significant memory word
// - load-to-decimal never writes memory
// - store-to-alnum expands two registers to three words, zero zones
// - store-to-alnum uses low register sign, registers unchanged
// - zero-suppress load blanks leading zeros and commas
// - zero-suppress load keeps signs, never writes memory
// - multiword suppress operand is consecutive, addressed at its top word; the code reads one word only, at the effective address
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module link_sense_convert_exec
    import lsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [24:0] i_instr,
    input wire logic [14:0] i_ctrl_count,
    input wire logic [14:0] i_mar,
    input wire logic [194:0] i_chan_addr,
    input wire logic [14:0] i_xr_data,
    input wire logic [24:0] i_mem_rdata,
    input wire logic [24:0] i_ar_lo,
    input wire logic [24:0] i_ar_hi,
    output logic [3:0] o_xr_sel,
    output logic [3:0] o_ar_sel,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [14:0] o_mem_addr,
    output logic [24:0] o_mem_wdata,
    output logic o_ar_wr,
    output logic o_ar_wr_hi,
    output logic [24:0] o_ar_wdata,
    output logic o_cc_load,
    output logic [14:0] o_cc_value,
    output logic [7:0] o_sense,
    output logic o_busy,
    output logic o_done
);
    typedef enum {ST_IDLE, ST_IND, ST_EXEC, ST_RD, ST_WR, ST_FIN} state_t;
    state_t state_q;
    logic [5:0] op;
    logic [3:0] des;
    logic [14:0] ea_q;
    logic [1:0] cnt_q;
    logic [74:0] buf_q;
    logic [14:0] sel_val;
    logic [14:0] chan_val;
    logic seen_q;
    logic [24:0] zs_word;
    logic zs_seen;
    logic [7:0] sense_q;
    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign op = i_instr[OP_HI:OP_LO];
    assign des = i_instr[DES_HI:DES_LO];
    assign o_xr_sel = i_instr[XR_HI:XR_LO];
    assign o_ar_sel = des;
    assign o_busy = (state_q != ST_IDLE);
    assign o_sense = sense_q;
    always_comb
    begin
        chan_val = 15'h0000;
        for (int c = 0; c < 13; c++)
        begin
            if (des == 4'(c + 3))
            begin
                chan_val = i_chan_addr[c*15 +: 15];
            end
        end
    end
    always_comb
    begin
        unique case (des)
            SEL_CTRL: sel_val = i_ctrl_count + ADDR_ONE;
            SEL_MAR: sel_val = i_mar + ADDR_ONE;
            4'h0: sel_val = i_ctrl_count + ADDR_ONE;
            default: sel_val = chan_val + ADDR_ONE;
        endcase
    end
    // zero suppression of a word; leading state starts from seen_q, which each start clears
    always_comb
    begin
        zs_word = i_mem_rdata;
        zs_seen = seen_q;
        for (int k = 3; k >= 0; k--)
        begin
            if (!zs_seen && (i_mem_rdata[k*6 +: 6] == CH_ZERO || i_mem_rdata[k*6 +: 6] == CH_COMMA))
            begin
                zs_word[k*6 +: 6] = CH_SPACE;
            end
            else
            begin
                zs_seen = 1'b1;
            end
        end
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= ST_IDLE;
            ea_q <= 15'h0000;
            cnt_q <= 2'h0;
            buf_q <= '0;
            seen_q <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_addr <= 15'h0000;
            o_mem_wdata <= 25'h0000000;
            o_ar_wr <= 1'b0;
            o_ar_wr_hi <= 1'b0;
            o_ar_wdata <= 25'h0000000;
            o_cc_load <= 1'b0;
            o_cc_value <= 15'h0000;
            o_done <= 1'b0;
        end
        else
        begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_ar_wr <= 1'b0;
            o_ar_wr_hi <= 1'b0;
            o_cc_load <= 1'b0;
            o_done <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (i_start)
                    begin
                        // index zero adds nothing, whatever the index file returns for it
                        ea_q <= {5'h00, i_instr[ADR_HI:0]} + ((o_xr_sel == 4'h0) ? 15'h0000 : i_xr_data);
                        seen_q <= 1'b0;
                        cnt_q <= 2'h0;
                        if (op == OP_SET_IND || op == OP_RESET_IND)
                        begin
                            state_q <= ST_FIN;
                        end
                        else if (i_instr[IND_BIT])
                        begin
                            o_mem_rd <= 1'b1;
                            o_mem_addr <= {5'h00, i_instr[ADR_HI:0]} + ((o_xr_sel == 4'h0) ? 15'h0000 : i_xr_data);
                            state_q <= ST_IND;
                        end
                        else
                        begin
                            state_q <= ST_EXEC;
                        end
                    end
                end
                ST_IND:
                begin
                    // the read pulse is still out; the pointer word stands one cycle later
                    if (!o_mem_rd)
                    begin
                        ea_q <= i_mem_rdata[14:0];
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    unique case (op)
                        OP_LINK:
                        begin
                            o_mem_wr <= 1'b1;
                            o_mem_addr <= ea_q;
                            o_mem_wdata <= {10'h000, sel_val};
                            o_cc_load <= 1'b1;
                            o_cc_value <= ea_q + ADDR_ONE;
                            state_q <= ST_FIN;
                        end
                        OP_JUMP_IND:
                        begin
                            o_cc_load <= 1'b1;
                            o_cc_value <= (des[3] && sense_q[des[2:0]]) ? ea_q : i_ctrl_count + ADDR_ONE;
                            state_q <= ST_FIN;
                        end
                        OP_LOAD_DEC, OP_ZSUP:
                        begin
                            o_mem_rd <= 1'b1;
                            o_mem_addr <= (op == OP_ZSUP) ? ea_q : ea_q - 15'h0002;
                            state_q <= ST_RD;
                        end
                        OP_STORE_ALNUM:
                        begin
                            // 12 digits of 4 bits -> 12 chars over 3 words, zone zero
                            // low register digits form word 0, which lands at the effective address
                            for (int d = 0; d < 12; d++)
                            begin
                                buf_q[(d/4)*25 + (d%4)*6 +: 6] <=
                                    {2'h0, (d < 6) ? i_ar_lo[(d%6)*4 +: 4] : i_ar_hi[(d%6)*4 +: 4]};
                            end
                            for (int w = 0; w < 3; w++)
                            begin
                                buf_q[w*25 + 24] <= i_ar_lo[24];
                            end
                            state_q <= ST_WR;
                        end
                        default: state_q <= ST_FIN;
                    endcase
                end
                ST_RD:
                begin
                    if (!o_mem_rd && op == OP_ZSUP)
                    begin
                        o_ar_wr <= 1'b1;
                        o_ar_wdata <= zs_word;
                        seen_q <= zs_seen;
                        state_q <= ST_FIN;
                    end
                    else if (!o_mem_rd)
                    begin
                        // strip zones: low nibbles of six characters kept, four from the second word read, two from the first
                        buf_q <= {i_mem_rdata, buf_q[74:25]};
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q == 2'h2)
                        begin
                            state_q <= ST_FIN;
                            o_ar_wr <= 1'b1;
                            o_ar_wr_hi <= 1'b1;
                            o_ar_wdata <= {i_mem_rdata[24], buf_q[71:68], buf_q[65:62], buf_q[59:56], buf_q[53:50],
                                           buf_q[46:43], buf_q[40:37]};
                        end
                        else
                        begin
                            o_mem_rd <= 1'b1;
                            o_mem_addr <= o_mem_addr + ADDR_ONE;
                        end
                    end
                end
                ST_WR:
                begin
                    o_mem_wr <= 1'b1;
                    o_mem_addr <= ea_q - 15'(2 - cnt_q);
                    o_mem_wdata <= buf_q[(2 - cnt_q)*25 +: 25];
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == 2'h2)
                    begin
                        state_q <= ST_FIN;
                    end
                end
                ST_FIN:
                begin
                    o_done <= 1'b1;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
    // ----------------------------------------
    // sense indicators
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sense_q <= SENSE_RESET;
        end
        else if (state_q == ST_IDLE && i_start && des[3])
        begin
            if (op == OP_SET_IND)
            begin
                sense_q[des[2:0]] <= 1'b1;
            end
            else if (op == OP_RESET_IND)
            begin
                sense_q[des[2:0]] <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_link_upper;
        @(posedge i_mclk) disable iff (!i_rstn) o_mem_wr && op == OP_LINK |-> o_mem_wdata[24:15] == 10'h000;
    endproperty
    a_link_upper: assert property (p_link_upper) else $error("link store upper bits nonzero");
    property p_link_jump;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_LINK |-> o_cc_load && o_cc_value == o_mem_addr + ADDR_ONE;
    endproperty
    a_link_jump: assert property (p_link_jump) else $error("link jump target wrong");
    property p_set;
        @(posedge i_mclk) disable iff (!i_rstn)
        state_q == ST_IDLE && i_start && op == OP_SET_IND && des[3] |=> sense_q[$past(des[2:0])];
    endproperty
    a_set: assert property (p_set) else $error("indicator not set");
    property p_reset;
        @(posedge i_mclk) disable iff (!i_rstn)
        state_q == ST_IDLE && i_start && op == OP_RESET_IND && des[3] |=> !sense_q[$past(des[2:0])] ##1 o_done;
    endproperty
    a_reset: assert property (p_reset) else $error("indicator not reset in two cycles");
    property p_test_keep;
        @(posedge i_mclk) disable iff (!i_rstn) state_q == ST_EXEC && op == OP_JUMP_IND |=> $stable(sense_q);
    endproperty
    a_test_keep: assert property (p_test_keep) else $error("test changed indicator");
    property p_no_mem_wr_load;
        @(posedge i_mclk) disable iff (!i_rstn) (op == OP_LOAD_DEC || op == OP_ZSUP) && o_busy |-> !o_mem_wr;
    endproperty
    a_no_mem_wr_load: assert property (p_no_mem_wr_load) else $error("load wrote memory");
    property p_no_ind_sense;
        @(posedge i_mclk) disable iff (!i_rstn)
        state_q == ST_IDLE && i_start && (op == OP_SET_IND || op == OP_RESET_IND) |=> !o_mem_rd;
    endproperty
    a_no_ind_sense: assert property (p_no_ind_sense) else $error("sense op read memory");
    property p_zs_sign;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_ar_wr && !o_ar_wr_hi && op == OP_ZSUP |-> o_ar_wdata[24] == $past(i_mem_rdata[24]);
    endproperty
    a_zs_sign: assert property (p_zs_sign) else $error("suppress lost sign");
    property p_link_ctrl;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_LINK && des == SEL_CTRL |-> o_mem_wdata[14:0] == $past(i_ctrl_count) + ADDR_ONE;
    endproperty
    a_link_ctrl: assert property (p_link_ctrl) else $error("link did not save control counter");
    property p_link_mar;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_LINK && des == SEL_MAR |-> o_mem_wdata[14:0] == $past(i_mar) + ADDR_ONE;
    endproperty
    a_link_mar: assert property (p_link_mar) else $error("link did not save address register");
    property p_link_chan;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_LINK && des >= SEL_CHAN_LO
        |-> o_mem_wdata[14:0] == $past(i_chan_addr[(des - SEL_CHAN_LO)*15 +: 15]) + ADDR_ONE;
    endproperty
    a_link_chan: assert property (p_link_chan) else $error("link did not save channel counter");
    property p_ind_read;
        @(posedge i_mclk) disable iff (!i_rstn)
        state_q == ST_IDLE && i_start && i_instr[IND_BIT] && (op == OP_LINK || op == OP_JUMP_IND) |=> o_mem_rd;
    endproperty
    a_ind_read: assert property (p_ind_read) else $error("indirect operand not fetched");
    property p_idx_zero;
        @(posedge i_mclk) disable iff (!i_rstn)
        state_q == ST_IDLE && i_start && o_xr_sel == 4'h0 |=> ea_q == {5'h00, $past(i_instr[ADR_HI:0])};
    endproperty
    a_idx_zero: assert property (p_idx_zero) else $error("index zero changed the address");
    property p_sense_only;
        @(posedge i_mclk) disable iff (!i_rstn)
        !(state_q == ST_IDLE && i_start && (op == OP_SET_IND || op == OP_RESET_IND)) |=> $stable(sense_q);
    endproperty
    a_sense_only: assert property (p_sense_only) else $error("indicator changed outside set or reset");
    property p_store_zone;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_STORE_ALNUM |-> (o_mem_wdata & ZONE_MASK) == 25'h0000000;
    endproperty
    a_store_zone: assert property (p_store_zone) else $error("store left zone bits set");
    property p_store_sign;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_mem_wr && op == OP_STORE_ALNUM |-> o_mem_wdata[24] == i_ar_lo[24];
    endproperty
    a_store_sign: assert property (p_store_sign) else $error("store sign not from low register");
    property p_load_sign;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_ar_wr_hi |-> o_ar_wdata[24] == $past(i_mem_rdata[24]);
    endproperty
    a_load_sign: assert property (p_load_sign) else $error("decimal load sign not from last word");
    property p_zs_blank;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_ar_wr && op == OP_ZSUP && $past(i_mem_rdata[23:18]) == CH_ZERO |-> o_ar_wdata[23:18] == CH_SPACE;
    endproperty
    a_zs_blank: assert property (p_zs_blank) else $error("leading zero not blanked");
endmodule
`default_nettype wire

// >>> hw/lsc_pkg.sv
// constants for the link, sense-indicator and conversion executor
// assumes a 25-bit word machine, bits numbered 1..25 mapped to [24:0]
package lsc_pkg;
    // ----------------------------------------
    // instruction fields
    // ----------------------------------------
    localparam int IND_BIT = 24;
    localparam int XR_HI = 23;
    localparam int XR_LO = 20;
    localparam int OP_HI = 19;
    localparam int OP_LO = 14;
    localparam int DES_HI = 13;
    localparam int DES_LO = 10;
    localparam int ADR_HI = 9;
    // ----------------------------------------
    // opcodes (octal codes written in hex)
    // ----------------------------------------
    localparam logic [5:0] OP_LINK = 6'h07;
    localparam logic [5:0] OP_JUMP_IND = 6'h30;
    localparam logic [5:0] OP_RESET_IND = 6'h31;
    localparam logic [5:0] OP_SET_IND = 6'h32;
    localparam logic [5:0] OP_STORE_ALNUM = 6'h39;
    localparam logic [5:0] OP_LOAD_DEC = 6'h3A;
    localparam logic [5:0] OP_ZSUP = 6'h3B;
    // ----------------------------------------
    // designator codes and characters
    // ----------------------------------------
    localparam logic [3:0] SEL_CTRL = 4'h1;
    localparam logic [3:0] SEL_MAR = 4'h2;
    localparam logic [3:0] SEL_CHAN_LO = 4'h3;
    localparam logic [5:0] CH_ZERO = 6'h03;
    localparam logic [5:0] CH_COMMA = 6'h32;
    localparam logic [5:0] CH_SPACE = 6'h00;
    localparam logic [14:0] ADDR_ONE = 15'h0001;
    localparam logic [7:0] SENSE_RESET = 8'h00;
    localparam logic [24:0] ZONE_MASK = 25'h0C30C30;
endpackage

// >>> tb/mem_proc_model.sv
// behavioural main memory, index registers and arithmetic registers
// assumes read data are wanted only in the cycle after a read pulse
`timescale 1ns/10ps
`default_nettype none
module mem_proc_model
(
    input wire logic i_mclk,
    input wire logic i_mem_rd,
    input wire logic i_mem_wr,
    input wire logic [14:0] i_mem_addr,
    input wire logic [24:0] i_mem_wdata,
    input wire logic [3:0] i_xr_sel,
    input wire logic [3:0] i_ar_sel,
    output logic [24:0] o_mem_rdata,
    output logic [14:0] o_xr_data,
    output logic [24:0] o_ar_lo,
    output logic [24:0] o_ar_hi
);
    logic [24:0] mem [0:255];
    logic [14:0] xr [0:15];
    logic [24:0] ar [0:15];
    // ----------------------------------------
    // memory
    // ----------------------------------------
    initial o_mem_rdata = 25'h0000000;
    // stale read data are inverted so a late sample cannot pass by luck
    always @(posedge i_mclk)
    begin
        o_mem_rdata <= i_mem_rd ? mem[i_mem_addr[7:0]] : ~o_mem_rdata;
        if (i_mem_wr)
        begin
            mem[i_mem_addr[7:0]] <= i_mem_wdata;
        end
    end
    // ----------------------------------------
    // registers; index 0 holds junk on purpose
    // ----------------------------------------
    assign o_xr_data = xr[i_xr_sel];
    assign o_ar_lo = ar[i_ar_sel];
    assign o_ar_hi = ar[i_ar_sel - 4'h1];
endmodule
`default_nettype wire

// >>> tb/link_sense_convert_exec_tb.sv
// self-checking bench for the link, sense and conversion executor
// assumes the memory/register model answers as the processor would
`timescale 1ns/10ps
`default_nettype none
module link_sense_convert_exec_tb;
    import lsc_pkg::*;
    logic i_mclk, i_rstn, i_start;
    logic [24:0] i_instr, i_mem_rdata, i_ar_lo, i_ar_hi, o_mem_wdata, o_ar_wdata, arw, wd [0:3];
    logic [14:0] i_ctrl_count, i_mar, i_xr_data, o_mem_addr, o_cc_value, ccv, val, wa [0:3], ra [0:3];
    logic [194:0] i_chan_addr;
    logic [3:0] o_xr_sel, o_ar_sel;
    logic o_mem_rd, o_mem_wr, o_ar_wr, o_ar_wr_hi, o_cc_load, o_busy, o_done, hi;
    logic [7:0] o_sense, exp_s;
    int mismatches, total_checks, nw, nr, na, s;
    link_sense_convert_exec dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start), .i_instr(i_instr),
        .i_ctrl_count(i_ctrl_count), .i_mar(i_mar), .i_chan_addr(i_chan_addr), .i_xr_data(i_xr_data),
        .i_mem_rdata(i_mem_rdata), .i_ar_lo(i_ar_lo), .i_ar_hi(i_ar_hi), .o_xr_sel(o_xr_sel),
        .o_ar_sel(o_ar_sel), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_ar_wr(o_ar_wr), .o_ar_wr_hi(o_ar_wr_hi), .o_ar_wdata(o_ar_wdata),
        .o_cc_load(o_cc_load), .o_cc_value(o_cc_value), .o_sense(o_sense), .o_busy(o_busy), .o_done(o_done));
    mem_proc_model m (.i_mclk(i_mclk), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
        .i_mem_wdata(o_mem_wdata), .i_xr_sel(o_xr_sel), .i_ar_sel(o_ar_sel), .o_mem_rdata(i_mem_rdata),
        .o_xr_data(i_xr_data), .o_ar_lo(i_ar_lo), .o_ar_hi(i_ar_hi));
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [24:0] exp, input logic [24:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [24:0] mk(logic ind, logic [3:0] x, logic [5:0] op, logic [3:0] d, logic [9:0] a);
        return {ind, x, op, d, a};
    endfunction
    // one instruction: start for one edge, then log every pulse until done
    task run(input logic [24:0] ins);
        int k;
        @(posedge i_mclk);
        i_instr <= ins;
        i_start <= 1'b1;
        @(posedge i_mclk);
        i_start <= 1'b0;
        nw = 0;
        nr = 0;
        na = 0;
        hi = 1'b0;
        for (k = 0; k < 40; k++)
        begin
            #1;
            if (o_mem_wr === 1'b1 && nw < 4)
            begin
                wa[nw] = o_mem_addr;
                wd[nw] = o_mem_wdata;
            end
            if (o_mem_rd === 1'b1 && nr < 4)
                ra[nr] = o_mem_addr;
            nw += (o_mem_wr === 1'b1);
            nr += (o_mem_rd === 1'b1);
            na += (o_ar_wr === 1'b1);
            if (o_ar_wr === 1'b1)
                arw = o_ar_wdata;
            if (o_ar_wr_hi === 1'b1)
                hi = 1'b1;
            if (o_cc_load === 1'b1)
                ccv = o_cc_value;
            if (o_done === 1'b1)
                break;
            @(posedge i_mclk);
        end
        if (k == 40)
        begin
            mismatches++;
            $display("CHECK FAILED done expected 1 seen 0");
            results();
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        i_rstn = 1'b0;
        i_start = 1'b0;
        i_instr = 25'h0000000;
        i_ctrl_count = 15'h0123;
        i_mar = 15'h2345;
        for (s = 0; s < 13; s++)
            i_chan_addr[s*15 +: 15] = 15'h1000 + 15'(s * 15'h0111);
        for (s = 0; s < 256; s++)
            m.mem[s] = 25'h1FFFFFF ^ 25'(s);
        for (s = 0; s < 16; s++)
        begin
            m.xr[s] = 15'h0070;
            m.ar[s] = 25'h0000000;
        end
        repeat (20) @(posedge i_mclk);
        chk("sense after reset", 25'(SENSE_RESET), 25'(o_sense));
        chk("done after reset", 25'h0, 25'(o_done));
        chk("busy after reset", 25'h0, 25'(o_busy));
        i_rstn <= 1'b1;
        for (s = 1; s < 16; s++)
        begin
            val = (s == 1) ? i_ctrl_count : (s == 2) ? i_mar : i_chan_addr[(s-3)*15 +: 15];
            run(mk(1'b0, 4'h0, OP_LINK, 4'(s), 10'h020 + 10'(s)));
            chk("link word", {10'h000, val + ADDR_ONE}, wd[0]);
            chk("link addr", 25'(15'h0020 + 15'(s)), 25'(wa[0]));
            chk("link cc", 25'(15'h0021 + 15'(s)), 25'(ccv));
        end
        m.xr[5] = 15'h0010;
        m.mem[8'h45] = {10'h3FF, 15'h0090};
        run(mk(1'b1, 4'h5, OP_LINK, 4'h1, 10'h035));
        chk("link indirect addr", 25'h0000090, 25'(wa[0]));
        chk("link indirect cc", 25'h0000091, 25'(ccv));
        chk("link writes", 25'h1, 25'(nw));
        $display("test link done");
        exp_s = SENSE_RESET;
        for (s = 0; s < 8; s++)
        begin
            run(mk(1'b1, 4'hF, OP_SET_IND, 4'h8 + 4'(s), 10'h3FF));
            exp_s[s] = 1'b1;
            chk("sense set", 25'(exp_s), 25'(o_sense));
            chk("set memory use", 25'h0, 25'(nr + nw));
        end
        run(mk(1'b1, 4'hF, OP_RESET_IND, 4'hB, 10'h155));
        exp_s[3] = 1'b0;
        chk("sense reset", 25'(exp_s), 25'(o_sense));
        chk("reset memory use", 25'h0, 25'(nr + nw));
        run(mk(1'b0, 4'h0, OP_JUMP_IND, 4'hA, 10'h0C8));
        chk("jump set cc", 25'h00000C8, 25'(ccv));
        run(mk(1'b0, 4'h0, OP_JUMP_IND, 4'hB, 10'h0C8));
        chk("jump clear cc", 25'(i_ctrl_count + ADDR_ONE), 25'(ccv));
        m.mem[8'h50] = {10'h2AA, 15'h0077};
        run(mk(1'b1, 4'h0, OP_JUMP_IND, 4'h8, 10'h050));
        chk("jump indirect cc", 25'h0000077, 25'(ccv));
        chk("sense kept", 25'(exp_s), 25'(o_sense));
        $display("test sense done");
        m.mem[8'h60] = 25'h0041041;
        m.mem[8'h61] = 25'h0082082;
        m.mem[8'h62] = 25'h10C30C3;
        run(mk(1'b0, 4'h0, OP_LOAD_DEC, 4'hC, 10'h062));
        for (s = 0; s < 3; s++)
            chk("load read addr", 25'(15'h0060 + 15'(s)), 25'(ra[s]));
        chk("load sign", 25'h1, 25'(arw[24]));
        chk("load pair", 25'h1, 25'(hi));
        chk("load writes", 25'h0, 25'(nw));
        m.ar[12] = 25'h1123456;
        m.ar[11] = 25'h0654321;
        run(mk(1'b0, 4'h0, OP_STORE_ALNUM, 4'hC, 10'h083));
        chk("store count", 25'h3, 25'(nw));
        chk("store reg writes", 25'h0, 25'(na));
        chk("store high word", 25'h1185103, wd[0]);
        chk("store mid word", 25'h1081042, wd[1]);
        chk("store low word", 25'h10C4146, wd[2]);
        for (s = 0; s < 3; s++)
        begin
            chk("store addr", 25'(15'h0081 + 15'(s)), 25'(wa[s]));
            chk("store sign", 25'h1, 25'(wd[s][24]));
            chk("store zones", 25'h0, wd[s] & 25'h0C30C30);
        end
        // single-word operand addressed at its most significant word
        m.mem[8'h70] = {1'b1, CH_ZERO, CH_COMMA, 6'h05, CH_ZERO};
        run(mk(1'b0, 4'h0, OP_ZSUP, 4'hC, 10'h070));
        chk("suppress data", {1'b1, CH_SPACE, CH_SPACE, 6'h05, CH_ZERO}, arw);
        chk("suppress writes", 25'h0, 25'(nw));
        $display("test convert done");
        results();
    end
endmodule
`default_nettype wire
